/* File: hw/mce_bank_pkg.sv */
// constants, layouts and carrier types for the extended error bank array
// assumes one hardware thread and one core clock
package mce_bank_pkg;
   localparam int unsigned NUM_BANKS    = 64;
   localparam int unsigned REGS_PER_BNK = 16;
   localparam int unsigned MEM_WORDS    = NUM_BANKS * REGS_PER_BNK;
   localparam int unsigned LOG_STEPS    = 8;

   // local slot within a bank
   localparam logic [3:0] REG_CTL    = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_ADDR   = 4'h2;
   localparam logic [3:0] REG_MISC0  = 4'h3;
   localparam logic [3:0] REG_CONFIG = 4'h4;
   localparam logic [3:0] REG_IDENT  = 4'h5;
   localparam logic [3:0] REG_SYND   = 4'h6;
   localparam logic [3:0] REG_RSVD   = 4'h7;
   localparam logic [3:0] REG_DESTAT = 4'h8;
   localparam logic [3:0] REG_DEADDR = 4'h9;
   localparam logic [3:0] REG_MISC1  = 4'hA;
   localparam logic [3:0] REG_MISC4  = 4'hD;
   localparam logic [3:0] REG_SYND1  = 4'hE;
   localparam logic [3:0] REG_SYND2  = 4'hF;

   // legacy alias window covers banks 0..31, four words each
   localparam int unsigned LEGACY_BANKS = 32;

   // configuration bit positions
   localparam int unsigned CFG_EXT      = 0;
   localparam int unsigned CFG_DLOG_CAP = 2;
   localparam int unsigned CFG_DIRQ_CAP = 5;
   localparam int unsigned CFG_CODE_CAP = 7;
   localparam int unsigned CFG_LSB_CAP  = 8;
   localparam int unsigned CFG_FRU      = 9;
   localparam int unsigned CFG_EXT_ACK  = 32;
   localparam int unsigned CFG_DLOG_EN  = 34;
   localparam int unsigned CFG_DIRQ_LO  = 37;
   localparam int unsigned CFG_IRQ_EN   = 40;
   localparam logic [63:0] CFG_WMASK    = 64'h0000_0165_0000_0000;

   // status / deferred status bit positions
   localparam int unsigned ST_VALID = 63;
   localparam int unsigned ST_OVF   = 62;
   localparam int unsigned ST_UC    = 61;
   localparam int unsigned ST_ADDRESS_VALID_FLAG = 58;
   localparam int unsigned ST_SYNDROME_VALID_FLAG = 53;
   localparam int unsigned ST_DEFER = 44;
   localparam int unsigned ST_LSB   = 24;

   // miscellaneous thresholding layout
   localparam int unsigned MISC_INTP = 60;
   localparam int unsigned MISC_CNTE = 51;
   localparam int unsigned MISC_OF   = 48;
   localparam int unsigned MISC_CNT  = 32;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [63:0] MISC_WMASK = 64'h00FF_FFFF_0000_0000;
   localparam logic [63:0] MISC0_INIT = 64'hC000_0000_0100_0000;
   localparam logic [63:0] MISCN_INIT = 64'hC000_0000_0000_0000;

   // deferred interrupt kinds
   localparam logic [1:0] DIRQ_NONE = 2'h0;
   localparam logic [1:0] DIRQ_APIC = 2'h1;
   localparam logic [1:0] DIRQ_SMI  = 2'h2;

   typedef enum logic [1:0] {ERR_CORR, ERR_DEFER, ERR_UNCORR, ERR_FATAL} err_kind_t;

   typedef struct packed {
      err_kind_t      kind;
      logic [5:0]     bank;
      logic [63:0]    addr;
      logic           addr_valid;
      logic [63:0]    synd;
      logic           synd_valid;
      logic [15:0]    code;
      logic [15:0]    ext_code;
      logic [5:0]     lsb;
      logic [127:0]   fru_text;
      logic [127:0]   impl_info;
   } err_report_t;

   typedef struct packed {
      logic           req;
      logic           we;
      logic           legacy;
      logic [11:0]    addr;
      logic [63:0]    wdata;
   } msr_req_t;
endpackage

/* File: hw/mce_bank.sv */
// extended machine-check bank array: 64 banks of sixteen 64-bit registers
// assumes a register-access port from the core and an error source on clk
// Notes on behaviour
// - 64 banks, sixteen words each, upper window reserved
// - fixed slot order inside each bank
// - banks 0-31 legacy words alias shared storage
// - config bit 0 always reads one
// - corrected interrupt only when enabled and present
// - bits 38:37 pick deferred interrupt kind
// - bit 34 adds deferred errors to main log
// - syndrome and misc logging ignores bit 34
// - unacknowledged extension makes uncorrected errors fatal
// - bit 9 selects unit text in syndromes
// - bit 8 reports address lsb in status
// - bit 7 enables deferred status error codes
// - deferred interrupt needs both kind and log support
// - bit 2 reports deferred log control support
// - identification fields type, high, hwid, low
// - syndrome tied to status syndrome-valid flags
// - deferred error reaches deferred status, or only sets its overflow bit if already valid
// - deferred status flag bits writable by software
// - deferred address shares main address format
// - syndromes 1-2 hardware written, misc 1-4 only by init and software
// - threshold counter saturates, sets overflow
`timescale 1ns/1ps
module mce_bank import mce_bank_pkg::*; #(
   parameter logic [15:0] BANK_TYPE  = 16'h0001,  // arbitrary
   parameter logic [11:0] HW_IDENT   = 12'h0A5,   // arbitrary
   parameter logic [3:0]  INST_HIGH  = 4'h0,
   parameter logic        DLOG_CAP   = 1'b1,
   parameter logic        DIRQ_CAP   = 1'b1,
   parameter logic        CODE_CAP   = 1'b1,
   parameter logic        LSB_CAP    = 1'b1,
   parameter logic        FRU_CAP    = 1'b0,
   parameter logic        IRQ_AVAIL  = 1'b1
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // register access
   input  wire msr_req_t    msr,
   output logic             msr_ack,
   output logic             msr_fault,
   output logic [63:0]      msr_rdata,
   // error source
   input  wire logic        err_valid,
   input  wire err_report_t err_in,
   output logic             err_ready,
   // interrupt setup
   input  wire logic [3:0]  threshold_vector_offset,
   // signalling
   output logic             corr_irq,
   output logic [3:0]       corr_irq_vector,
   output logic             defer_apic_irq,
   output logic             defer_smi,
   output logic             system_fatal
);
   typedef enum logic [1:0] {PH_INIT, PH_IDLE, PH_LOG, PH_DONE} phase_t;

   typedef struct packed {
      phase_t         phase;
      logic [9:0]     step;
      err_report_t    e;
      logic [63:0]    cfg;
      logic           take_main;
      logic           defer_ovf;
      logic           ack;
      logic           fault;
      logic [63:0]    rdata;
      logic           acc_cfg;
      logic           acc_rsvd;
      logic           acc_ident;
      logic [5:0]     acc_bank;
      logic           err_ready;
      logic           corr_irq;
      logic [3:0]     vector;
      logic           dapic;
      logic           dsmi;
      logic           fatal;
   } state_t;

   state_t      st;
   state_t      next_st;
   logic [63:0] mem [MEM_WORDS];
   logic        wr_en;
   logic [9:0]  wr_idx;
   logic [63:0] wr_data;

   function automatic logic [63:0] ident_word(input logic [5:0] bank);
      ident_word = {BANK_TYPE, INST_HIGH, HW_IDENT, 26'h0, bank};
   endfunction

   function automatic logic [63:0] cfg_word(input logic [63:0] stored);
      logic [63:0] w;
      w = stored & CFG_WMASK;
      w[CFG_EXT]      = 1'b1;
      w[CFG_DLOG_CAP] = DLOG_CAP;
      w[CFG_DIRQ_CAP] = DIRQ_CAP;
      w[CFG_CODE_CAP] = CODE_CAP;
      w[CFG_LSB_CAP]  = LSB_CAP;
      w[CFG_FRU]      = FRU_CAP;
      cfg_word = w;
   endfunction

   // status image shared by main and deferred logs
   function automatic logic [63:0] status_word(input err_report_t e, input logic codes, input logic lsb_on,
                                               input logic ovf);
      logic [63:0] w;
      w = 64'h0;
      w[ST_VALID] = 1'b1;
      w[ST_OVF]   = ovf;
      w[ST_UC]    = (e.kind == ERR_UNCORR) || (e.kind == ERR_FATAL);
      w[ST_ADDRESS_VALID_FLAG] = e.addr_valid;
      w[ST_SYNDROME_VALID_FLAG] = e.synd_valid;
      w[ST_DEFER] = (e.kind == ERR_DEFER);
      if (codes) begin
         w[31:0] = {e.ext_code, e.code};
      end
      if (lsb_on) begin
         w[ST_LSB +: 6] = e.lsb;
      end
      status_word = w;
   endfunction

   // the single storage is what makes the legacy view a true alias
   function automatic logic [9:0] map_index(input msr_req_t m);
      if (m.legacy) begin
         map_index = {1'b0, m.addr[6:2], 2'b00, m.addr[1:0]};
      end else begin
         map_index = m.addr[9:0];
      end
   endfunction

   logic [9:0]  acc_idx;
   logic        acc_bad;
   logic        take_err;
   logic        take_msr;
   logic [63:0] cfg_in;
   logic [63:0] stat_in;
   logic [63:0] dstat_in;
   logic [63:0] old_word;
   logic [15:0] cnt;

   always_comb begin
      acc_idx  = map_index(msr);
      acc_bad  = msr.legacy ? (msr.addr[11:7] != 5'h0) : (msr.addr[11:10] != 2'h0);
      take_err = (st.phase == PH_IDLE) && err_valid;
      take_msr = (st.phase == PH_IDLE) && !err_valid && msr.req && !st.ack;
      cfg_in   = mem[{err_in.bank, REG_CONFIG}];
      stat_in  = mem[{st.e.bank, REG_STATUS}];
      dstat_in = mem[{err_in.bank, REG_DESTAT}];
      old_word = mem[wr_idx];
      cnt      = old_word[MISC_CNT +: 16];
   end

   always_comb begin
      wr_en   = 1'b0;
      wr_idx  = acc_idx;
      wr_data = msr.wdata;
      if (st.phase == PH_INIT) begin
         wr_en   = 1'b1;
         wr_idx  = st.step;
         wr_data = 64'h0;
         if (st.step[3:0] == REG_MISC0) begin
            wr_data = MISC0_INIT;
         end else if (st.step[3:0] >= REG_MISC1 && st.step[3:0] <= REG_MISC4) begin
            wr_data = MISCN_INIT;
         end
      end else if (take_msr && msr.we && !acc_bad) begin
         wr_en = 1'b1;
         if (acc_idx[3:0] == REG_CONFIG) begin
            wr_data = msr.wdata & CFG_WMASK;
            if (!DLOG_CAP) begin
               wr_data[CFG_DLOG_EN] = 1'b0;
            end
         end else if (acc_idx[3:0] == REG_MISC0 || (acc_idx[3:0] >= REG_MISC1 && acc_idx[3:0] <= REG_MISC4)) begin
            wr_data = (mem[acc_idx] & ~MISC_WMASK) | (msr.wdata & MISC_WMASK);
         end else if (acc_idx[3:0] == REG_RSVD || acc_idx[3:0] == REG_IDENT) begin
            wr_en = 1'b0;
         end
         // status words take any software value, clears included
      end else if (st.phase == PH_LOG) begin
         case (st.step[2:0])
            3'd0: begin
               wr_idx  = {st.e.bank, REG_STATUS};
               wr_en   = st.take_main;
               wr_data = status_word(st.e, 1'b1, st.cfg[CFG_LSB_CAP], old_word[ST_VALID]);
               if (old_word[ST_VALID] && old_word[ST_UC] && st.e.kind == ERR_CORR) begin
                  // an uncorrected entry outranks a corrected one
                  wr_data = old_word;
                  wr_data[ST_OVF] = 1'b1;
               end
            end
            3'd1: begin
               wr_idx  = {st.e.bank, REG_ADDR};
               // a kept uncorrected entry keeps its own address as well
               wr_en   = st.take_main && st.e.addr_valid && !(st.e.kind == ERR_CORR && stat_in[ST_UC]);
               wr_data = st.e.addr;
            end
            3'd2: begin
               wr_idx  = {st.e.bank, REG_SYND};
               wr_en   = st.e.synd_valid;
               wr_data = st.e.synd;
            end
            3'd3: begin
               wr_idx  = {st.e.bank, REG_SYND1};
               wr_en   = st.e.synd_valid;
               wr_data = st.cfg[CFG_FRU] ? st.e.fru_text[63:0] : st.e.impl_info[63:0];
            end
            3'd4: begin
               wr_idx  = {st.e.bank, REG_SYND2};
               wr_en   = st.e.synd_valid;
               wr_data = st.cfg[CFG_FRU] ? st.e.fru_text[127:64] : st.e.impl_info[127:64];
            end
            3'd5: begin
               wr_idx  = {st.e.bank, REG_DESTAT};
               wr_en   = (st.e.kind == ERR_DEFER);
               wr_data = status_word(st.e, st.cfg[CFG_CODE_CAP], st.cfg[CFG_LSB_CAP], 1'b0);
               if (st.defer_ovf) begin
                  // the earlier unhandled entry is kept, loss is flagged
                  wr_data = old_word;
                  wr_data[ST_OVF] = 1'b1;
               end
            end
            3'd6: begin
               wr_idx  = {st.e.bank, REG_DEADDR};
               wr_en   = (st.e.kind == ERR_DEFER) && !st.defer_ovf && st.e.addr_valid;
               wr_data = st.e.addr;
            end
            default: begin
               wr_idx  = {st.e.bank, REG_MISC0};
               wr_en   = (st.e.kind == ERR_CORR) && old_word[MISC_CNTE];
               wr_data = old_word;
               if (cnt != CNT_MAX) begin
                  wr_data[MISC_CNT +: 16] = cnt + 16'h1;
               end
               if (cnt >= CNT_MAX - 16'h1) begin
                  wr_data[MISC_OF] = 1'b1;
               end
            end
         endcase
      end
   end

   always_comb begin
      next_st           = st;
      next_st.ack       = 1'b0;
      next_st.corr_irq  = 1'b0;
      next_st.dapic     = 1'b0;
      next_st.dsmi      = 1'b0;
      next_st.fatal     = 1'b0;
      next_st.err_ready = 1'b0;
      case (st.phase)
         PH_INIT: begin
            next_st.step = st.step + 10'h1;
            if (st.step == 10'(MEM_WORDS - 1)) begin
               next_st.phase     = PH_IDLE;
               next_st.err_ready = 1'b1;
            end
         end
         PH_IDLE: begin
            next_st.err_ready = !err_valid;
            if (take_err) begin
               next_st.phase     = PH_LOG;
               next_st.step      = 10'h0;
               next_st.e         = err_in;
               next_st.cfg       = cfg_word(cfg_in);
               next_st.take_main = (err_in.kind != ERR_DEFER) || cfg_in[CFG_DLOG_EN];
               next_st.defer_ovf = dstat_in[ST_VALID];
               next_st.err_ready = 1'b0;
            end else if (take_msr) begin
               next_st.ack       = 1'b1;
               next_st.fault     = acc_bad;
               next_st.acc_cfg   = !acc_bad && acc_idx[3:0] == REG_CONFIG;
               next_st.acc_rsvd  = !acc_bad && acc_idx[3:0] == REG_RSVD;
               next_st.acc_ident = !acc_bad && acc_idx[3:0] == REG_IDENT;
               next_st.acc_bank  = acc_idx[9:4];
               if (acc_bad) begin
                  next_st.rdata = 64'h0;
               end else if (acc_idx[3:0] == REG_CONFIG) begin
                  next_st.rdata = cfg_word(mem[acc_idx]);
               end else if (acc_idx[3:0] == REG_IDENT) begin
                  next_st.rdata = ident_word(acc_idx[9:4]);
               end else if (acc_idx[3:0] == REG_RSVD) begin
                  next_st.rdata = 64'h0;
               end else begin
                  next_st.rdata = mem[acc_idx];
               end
            end
         end
         PH_LOG: begin
            next_st.step = st.step + 10'h1;
            if (st.step == 10'(LOG_STEPS - 1)) begin
               next_st.phase = PH_DONE;
            end
         end
         default: begin
            next_st.phase     = PH_IDLE;
            next_st.err_ready = 1'b1;
            next_st.vector    = threshold_vector_offset;
            if (st.e.kind == ERR_CORR) begin
               next_st.corr_irq = st.cfg[CFG_IRQ_EN] && IRQ_AVAIL;
            end
            if (st.e.kind == ERR_DEFER && st.cfg[CFG_EXT_ACK] && st.cfg[CFG_DIRQ_CAP] && st.cfg[CFG_DLOG_CAP]) begin
               next_st.dapic = st.cfg[CFG_DIRQ_LO +: 2] == DIRQ_APIC;
               next_st.dsmi  = st.cfg[CFG_DIRQ_LO +: 2] == DIRQ_SMI;
            end
            next_st.fatal = (st.e.kind == ERR_FATAL) ||
                            ((st.e.kind == ERR_UNCORR) && !st.cfg[CFG_EXT_ACK]);
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // no reset on storage; the init sweep zeroes it instead, misc words get their init values
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_comb begin
      msr_ack         = st.ack;
      msr_fault       = st.fault;
      msr_rdata       = st.rdata;
      err_ready       = st.err_ready;
      corr_irq        = st.corr_irq;
      corr_irq_vector = st.vector;
      defer_apic_irq  = st.dapic;
      defer_smi       = st.dsmi;
      system_fatal    = st.fatal;
   end

   sequence fatal_taken_s;
      take_err && (err_in.kind == ERR_UNCORR) && !cfg_in[CFG_EXT_ACK];
   endsequence

   sequence fatal_raised_s;
      ##[10:10] system_fatal;
   endsequence

   fatal_unack_a: assert property (@(posedge clk) disable iff (!nrst)
      fatal_taken_s |-> fatal_raised_s) else $error("uncorrected error without ack not fatal");

   cfg_ext_bit_a: assert property (@(posedge clk) disable iff (!nrst)
      msr_ack && st.acc_cfg |-> msr_rdata[CFG_EXT]) else $error("config bit 0 reads zero");

   rsvd_reads_a: assert property (@(posedge clk) disable iff (!nrst)
      msr_ack && st.acc_rsvd |-> msr_rdata == 64'h0) else $error("reserved slot not zero");

   window_fault_a: assert property (@(posedge clk) disable iff (!nrst)
      msr_ack && msr_fault |-> msr_rdata == 64'h0 && !$past(wr_en)) else $error("reserved window touched");

   ident_low_a: assert property (@(posedge clk) disable iff (!nrst)
      msr_ack && st.acc_ident |-> msr_rdata[31:0] == {26'h0, st.acc_bank} && msr_rdata[43:32] == HW_IDENT)
      else $error("identification word wrong");

   corr_gate_a: assert property (@(posedge clk) disable iff (!nrst)
      corr_irq |-> $past(st.cfg[CFG_IRQ_EN]) && $past(st.e.kind) == ERR_CORR) else $error("corrected irq ungated");

   defer_smi_a: assert property (@(posedge clk) disable iff (!nrst)
      defer_smi |-> $past(st.cfg[CFG_DIRQ_LO +: 2]) == DIRQ_SMI && $past(st.cfg[CFG_EXT_ACK]))
      else $error("smi without selection");

   cnt_saturate_a: assert property (@(posedge clk) disable iff (!nrst)
      st.phase == PH_LOG && st.step[2:0] == 3'd7 && wr_en && cnt == CNT_MAX |->
      wr_data[MISC_CNT +: 16] == CNT_MAX && wr_data[MISC_OF]) else $error("counter rolled over");

   destat_codes_a: assert property (@(posedge clk) disable iff (!nrst)
      st.phase == PH_LOG && st.step[2:0] == 3'd5 && wr_en && !st.defer_ovf
      |-> wr_data[15:0] == (st.cfg[CFG_CODE_CAP] ? st.e.code : 16'h0)) else $error("deferred code field wrong");

   main_skip_a: assert property (@(posedge clk) disable iff (!nrst)
      st.phase == PH_LOG && st.step[2:0] == 3'd0 && st.e.kind == ERR_DEFER && !st.cfg[CFG_DLOG_EN] |-> !wr_en)
      else $error("deferred error reached main status");
endmodule

/* File: verif/mce_bank_bench.sv */
// self-checking bench for the extended error bank array
// assumes default capability parameters except the identity values set here
`timescale 1ns/1ps
module mce_bank_bench;
   import mce_bank_pkg::*;
   logic        clk;
   logic        nrst;
   msr_req_t    msr;
   logic        msr_ack;
   logic        msr_fault;
   logic [63:0] msr_rdata;
   logic        err_valid;
   err_report_t err_in;
   logic        err_ready;
   logic        corr_irq;
   logic [3:0]  corr_irq_vector;
   logic        defer_apic_irq;
   logic        defer_smi;
   logic        system_fatal;
   logic [63:0] rd;
   logic        flt;
   int          n_fail;
   int          compares;
   int          n_corr;
   int          n_apic;
   int          n_smi;
   int          n_fatal;

   mce_bank #(.BANK_TYPE(16'h1234), .HW_IDENT(12'h0A5), .INST_HIGH(4'h3)) u_mce_bank (
      .clk(clk), .nrst(nrst), .msr(msr), .msr_ack(msr_ack), .msr_fault(msr_fault),
      .msr_rdata(msr_rdata), .err_valid(err_valid), .err_in(err_in), .err_ready(err_ready),
      .threshold_vector_offset(4'h9), .corr_irq(corr_irq), .corr_irq_vector(corr_irq_vector),
      .defer_apic_irq(defer_apic_irq), .defer_smi(defer_smi), .system_fatal(system_fatal));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // pulses last one cycle, so each edge sees a pulse at most once
   always @(posedge clk) begin
      n_corr  <= n_corr + int'(corr_irq === 1'b1);
      n_apic  <= n_apic + int'(defer_apic_irq === 1'b1);
      n_smi   <= n_smi + int'(defer_smi === 1'b1);
      n_fatal <= n_fatal + int'(system_fatal === 1'b1);
   end

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [11:0] ea(input int b, input logic [3:0] s);
      return {2'b00, 6'(b), s};
   endfunction

   task automatic acc(input logic we, input logic lg, input logic [11:0] a, input logic [63:0] wd);
      int i;
      @(negedge clk);
      msr = '{req: 1'b1, we: we, legacy: lg, addr: a, wdata: wd};
      for (i = 0; i < 50 && msr_ack !== 1'b1; i++) @(negedge clk);
      if (i == 50) begin
         n_fail++;
         $display("wrong value msr_ack expected 1 seen 0");
      end
      rd = msr_rdata;
      flt = msr_fault;
      msr.req = 1'b0;
   endtask

   task automatic rdc(input string what, input logic lg, input logic [11:0] a, input logic [63:0] exp);
      acc(1'b0, lg, a, 64'h0);
      chk(what, exp, rd);
   endtask

   function automatic err_report_t mk(input err_kind_t k, input int b, input logic [15:0] c,
                                      input logic [15:0] x);
      err_report_t r;
      r = '0;
      r.kind = k;
      r.bank = 6'(b);
      r.addr = 64'h0000_0000_0001_0000 + 64'(b);
      r.addr_valid = 1'b1;
      r.synd = 64'h5A5A_0000_0000_A5A5;
      r.synd_valid = 1'b1;
      r.code = c;
      r.ext_code = x;
      r.lsb = 6'h0C;
      r.impl_info = {64'h2222_0000_0000_2222, 64'h1111_0000_0000_1111};
      return r;
   endfunction

   // hold the offer until the block drops ready, so it is never lost
   task automatic send(input err_report_t r);
      int i;
      @(negedge clk);
      err_in = r;
      err_valid = 1'b1;
      for (i = 0; i < 40 && err_ready !== 1'b0; i++) @(negedge clk);
      err_valid = 1'b0;
      for (i = 0; i < 40 && err_ready !== 1'b1; i++) @(negedge clk);
      if (i == 40) begin
         n_fail++;
         $display("wrong value err_ready expected 1 seen 0");
      end
      @(negedge clk);
   endtask

   initial begin
      #(8 * 20000);
      n_fail++;
      $display("wrong value watchdog expected done seen hang");
      end_of_test();
   end

   initial begin
      int i;
      nrst = 1'b0;
      msr = '0;
      err_valid = 1'b0;
      err_in = '0;
      {n_fail, compares, n_corr, n_apic, n_smi, n_fatal} = '0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      for (i = 0; i < 1200 && err_ready !== 1'b1; i++) @(negedge clk);
      rdc("config", 1'b0, ea(3, REG_CONFIG), 64'h0000_0000_0000_01A5);
      rdc("ident", 1'b0, ea(5, REG_IDENT), 64'h1234_30A5_0000_0005);
      acc(1'b1, 1'b0, ea(5, REG_IDENT), 64'hFFFF_FFFF_FFFF_FFFF);
      rdc("ident", 1'b0, ea(5, REG_IDENT), 64'h1234_30A5_0000_0005);
      rdc("misc0", 1'b0, ea(9, REG_MISC0), 64'hC000_0000_0100_0000);
      rdc("misc4", 1'b0, ea(9, REG_MISC4), 64'hC000_0000_0000_0000);
      acc(1'b1, 1'b0, ea(4, REG_RSVD), 64'hFFFF_FFFF_FFFF_FFFF);
      rdc("slot7", 1'b0, ea(4, REG_RSVD), 64'h0);
      acc(1'b1, 1'b0, 12'h400, 64'hFFFF_FFFF_FFFF_FFFF);
      chk("fault", 64'h1, 64'(flt));
      rdc("window", 1'b0, 12'h400, 64'h0);
      chk("fault", 64'h1, 64'(flt));
      rdc("last", 1'b0, ea(63, REG_SYND2), 64'h0);
      chk("fault", 64'h0, 64'(flt));
      acc(1'b1, 1'b0, ea(31, REG_STATUS), 64'h0123_4567_89AB_CDEF);
      rdc("legacy", 1'b1, 12'h07D, 64'h0123_4567_89AB_CDEF);
      acc(1'b1, 1'b1, 12'h008, 64'h0000_0000_0000_00FF);
      rdc("alias", 1'b0, ea(2, REG_CTL), 64'h0000_0000_0000_00FF);
      acc(1'b1, 1'b0, ea(31, REG_STATUS), 64'h0);
      acc(1'b1, 1'b0, ea(6, REG_CONFIG), 64'hFFFF_FFFF_FFFF_FFFF);
      rdc("config", 1'b0, ea(6, REG_CONFIG), 64'h0000_0165_0000_01A5);
      // deferred errors: acknowledge set, local interrupt, main log off
      acc(1'b1, 1'b0, ea(1, REG_CONFIG), 64'h0000_0021_0000_0000);
      send(mk(ERR_DEFER, 1, 16'h1234, 16'hC0AB));
      chk("apic", 64'h1, 64'(n_apic));
      rdc("status", 1'b0, ea(1, REG_STATUS), 64'h0);
      rdc("destat", 1'b0, ea(1, REG_DESTAT), 64'h8420_1000_CCAB_1234);
      rdc("deaddr", 1'b0, ea(1, REG_DEADDR), 64'h0000_0000_0001_0001);
      rdc("synd", 1'b0, ea(1, REG_SYND), 64'h5A5A_0000_0000_A5A5);
      rdc("synd1", 1'b0, ea(1, REG_SYND1), 64'h1111_0000_0000_1111);
      rdc("synd2", 1'b0, ea(1, REG_SYND2), 64'h2222_0000_0000_2222);
      // second deferred with main log on and the other interrupt kind
      acc(1'b1, 1'b0, ea(1, REG_CONFIG), 64'h0000_0045_0000_0000);
      send(mk(ERR_DEFER, 1, 16'h5678, 16'hC0CD));
      chk("smi", 64'h1, 64'(n_smi));
      chk("apic", 64'h1, 64'(n_apic));
      rdc("status", 1'b0, ea(1, REG_STATUS), 64'h8420_1000_CCCD_5678);
      rdc("destat", 1'b0, ea(1, REG_DESTAT), 64'hC420_1000_CCAB_1234);
      acc(1'b1, 1'b0, ea(1, REG_DESTAT), 64'h0);
      rdc("destat", 1'b0, ea(1, REG_DESTAT), 64'h0);
      // kind 00 gives no deferred interrupt
      acc(1'b1, 1'b0, ea(1, REG_CONFIG), 64'h0000_0001_0000_0000);
      send(mk(ERR_DEFER, 1, 16'h0001, 16'h0000));
      chk("defer none", 64'h2, 64'(n_apic + n_smi));
      // corrected errors drive the threshold counter to saturation
      acc(1'b1, 1'b0, ea(2, REG_CONFIG), 64'h0000_0100_0000_0000);
      acc(1'b1, 1'b0, ea(2, REG_MISC0), 64'h0008_FFFE_0000_0000);
      rdc("misc0", 1'b0, ea(2, REG_MISC0), 64'hC008_FFFE_0100_0000);
      send(mk(ERR_CORR, 2, 16'h0010, 16'h0000));
      chk("corr", 64'h1, 64'(n_corr));
      chk("vector", 64'h9, 64'(corr_irq_vector));
      rdc("misc0", 1'b0, ea(2, REG_MISC0), 64'hC009_FFFF_0100_0000);
      send(mk(ERR_CORR, 2, 16'h0010, 16'h0000));
      rdc("misc0", 1'b0, ea(2, REG_MISC0), 64'hC009_FFFF_0100_0000);
      send(mk(ERR_CORR, 3, 16'h0010, 16'h0000));
      chk("corr", 64'h2, 64'(n_corr));
      // uncorrected: fatal without acknowledge, not with it
      send(mk(ERR_UNCORR, 3, 16'h0020, 16'h0000));
      chk("fatal", 64'h1, 64'(n_fatal));
      send(mk(ERR_UNCORR, 1, 16'h0020, 16'h0000));
      chk("fatal", 64'h1, 64'(n_fatal));
      send(mk(ERR_FATAL, 1, 16'h0030, 16'h0000));
      chk("fatal", 64'h2, 64'(n_fatal));
      end_of_test();
   end
endmodule
